// ### core/sbi_defs.vh
`ifndef SBI_DEFS_VH
`define SBI_DEFS_VH
// 7-bit charger bus address
`define SBI_ADDR          7'h09
// register pointers
`define SBI_PTR_CTRL      8'h00
`define SBI_PTR_EVENT     8'h01
`define SBI_PTR_DELAY     8'h02
// control register bit positions
`define SBI_BIT_RST       0
`define SBI_BIT_DIS       1
// event register bit positions
`define SBI_BIT_RST_EV    0
`define SBI_BIT_DIS_EV    1
// bus timeout, 25 ms at 100 MHz
`define SBI_TIMEOUT_MS    25
`define SBI_CLK_KHZ       100000
`define SBI_TIMEOUT_CYC   (`SBI_TIMEOUT_MS * `SBI_CLK_KHZ)
// isolation delay unit, 1 ms
`define SBI_DELAY_UNIT_US 1000
`define SBI_CLK_MHZ       100
`define SBI_DELAY_UNIT_CYC (`SBI_DELAY_UNIT_US * `SBI_CLK_MHZ)
`define SBI_DELAY_RST     16'h0064
`endif

// ### core/sbi_sync.v
module sbi_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire mclk,
  input  wire arst_n,
  input  wire d,
  output reg  q
);
  reg s1_q;
  // first stage feeds only the second
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= RST_VAL;
      q    <= RST_VAL;
    end else begin
      s1_q <= d;
      q    <= s1_q;
    end
  end
endmodule

// ### core/sbi_top.v
// Notes on behaviour
// - reset bit pulses gate low, then self-clears
// - reset bit starts delay; switch off after
// - same delay sets switch off duration
// - disconnect: after delay, low when adapter gone
// - valid charger reconnects and clears disconnect bit
// - clock low past timeout aborts like stop
// - works from SMBus rates up to 400 kHz
// - bus clock independent; crossed into core clock
// - always ack own address, pointer, low and high byte
// - answers fixed address 0001001b
// - 16-bit registers, low byte first
// - write: addr, pointer, low, high, stop
// - read: pointer, restart, low ack, high nack
// - read-clear reset and disconnect event flags
`include "sbi_defs.vh"
module sbi_top #(
  parameter TIMEOUT_CYC = `SBI_TIMEOUT_CYC,
  parameter UNIT_CYC    = `SBI_DELAY_UNIT_CYC
) (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe,
  input  wire        adapter_valid_line,
  output reg         battery_switch_gate_drive,
  output reg         system_reset_request_bit,
  output reg         battery_disconnect_request_bit,
  output reg         reset_event_flag,
  output reg         disconnect_event_flag,
  output reg  [15:0] isolation_delay_q
);
////////////////////////////////////////////////////////////////////////////////
  wire scl_s;
  wire sda_s;
  wire adp_s;
  // sampled at 100 MHz: ample margin over 400 kHz bus
  sbi_sync #(.RST_VAL(1'b1)) u_scl (.mclk(mclk), .arst_n(arst_n),
    .d(scl_i), .q(scl_s));
  sbi_sync #(.RST_VAL(1'b1)) u_sda (.mclk(mclk), .arst_n(arst_n),
    .d(sda_i), .q(sda_s));
  sbi_sync #(.RST_VAL(1'b0)) u_adp (.mclk(mclk), .arst_n(arst_n),
    .d(adapter_valid_line), .q(adp_s));
  reg scl_q;
  reg sda_q;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_c  = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_c   = scl_s & scl_q & ~sda_q & sda_s;
////////////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_PTR  = 3'd2;
  localparam ST_WLO  = 3'd3;
  localparam ST_WHI  = 3'd4;
  localparam ST_RD   = 3'd5;
  localparam ST_DONE = 3'd6;
  reg  [2:0]  st_q;
  reg  [3:0]  bit_q;
  reg  [7:0]  sh_q;
  reg         ack_q;
  reg         rdack_q;
  reg         rd_hi_q;
  reg  [7:0]  ptr_q;
  reg  [7:0]  lo_q;
  reg  [15:0] rdw_q;
  reg  [31:0] to_q;
  reg         wr_stb;
  reg         rd_ev_clr;
  wire [15:0] rd_mux = (ptr_q == `SBI_PTR_CTRL) ?
    {14'h0000, battery_disconnect_request_bit, system_reset_request_bit} :
    (ptr_q == `SBI_PTR_EVENT) ?
    {14'h0000, disconnect_event_flag, reset_event_flag} :
    (ptr_q == `SBI_PTR_DELAY) ? isolation_delay_q : 16'h0000;
  wire        to_hit = (to_q == TIMEOUT_CYC - 1);
  wire [7:0]  byte_in = {sh_q[6:0], sda_s};
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE; bit_q <= 4'h0; sh_q <= 8'h00; ack_q <= 1'b0;
      rdack_q <= 1'b0; rd_hi_q <= 1'b0; ptr_q <= 8'h00; lo_q <= 8'h00;
      rdw_q <= 16'h0000; to_q <= 32'h0000_0000; wr_stb <= 1'b0;
      rd_ev_clr <= 1'b0; sda_o <= 1'b0; sda_oe <= 1'b0;
    end else begin
      wr_stb    <= 1'b0;
      rd_ev_clr <= 1'b0;
      if (scl_s || st_q == ST_IDLE) to_q <= 32'h0000_0000;
      else if (!to_hit) to_q <= to_q + 32'h0000_0001;
      if (stop_c || to_hit) begin
        st_q <= ST_IDLE; sda_oe <= 1'b0; ack_q <= 1'b0; rdack_q <= 1'b0;
      end else if (start_c) begin // repeated start keeps pointer
        st_q <= ST_ADDR; bit_q <= 4'h0; sda_oe <= 1'b0; ack_q <= 1'b0;
      end else if (scl_rise) begin
        if (rdack_q) begin
          rdack_q <= 1'b0;
          if (sda_s) st_q <= ST_DONE; // master nack ends read
        end else if (!ack_q && st_q != ST_IDLE && st_q != ST_DONE &&
                     st_q != ST_RD) begin
          sh_q  <= byte_in;
          bit_q <= bit_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          sda_oe <= 1'b0;
          if (st_q == ST_RD) begin
            sda_oe <= ~rdw_q[7];
            sda_o <= 1'b0;
            sh_q <= {rdw_q[6:0], 1'b0};
            bit_q <= 4'h1;
          end
        end else if (st_q == ST_RD && bit_q == 4'h8) begin
          sda_oe <= 1'b0; rdack_q <= 1'b1; bit_q <= 4'h0;
          rd_hi_q <= ~rd_hi_q;
          if (!rd_hi_q) sh_q <= rdw_q[15:8]; // low byte then high
          else rd_ev_clr <= (ptr_q == `SBI_PTR_EVENT);
        end else if (st_q == ST_RD && !rdack_q) begin
          sda_oe <= ~sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
          bit_q <= bit_q + 4'h1;
        end else if (st_q == ST_RD) begin
          sda_oe <= ~sh_q[7];
          sh_q <= {sh_q[6:0], 1'b0};
          bit_q <= 4'h1;
        end else if (bit_q == 4'h8) begin
          bit_q <= 4'h0;
          case (st_q)
            ST_ADDR: begin
              if (sh_q[7:1] == `SBI_ADDR) begin
                ack_q <= 1'b1; sda_oe <= 1'b1;
                if (sh_q[0]) begin
                  st_q <= ST_RD; rdw_q <= rd_mux; rd_hi_q <= 1'b0;
                end else st_q <= ST_PTR;
              end else st_q <= ST_DONE;
            end
            ST_PTR: begin
              ptr_q <= sh_q; st_q <= ST_WLO; ack_q <= 1'b1; sda_oe <= 1'b1;
            end
            ST_WLO: begin
              lo_q <= sh_q; st_q <= ST_WHI; ack_q <= 1'b1; sda_oe <= 1'b1;
            end
            ST_WHI: begin // word commits on high byte
              wr_stb <= 1'b1; st_q <= ST_DONE; ack_q <= 1'b1; sda_oe <= 1'b1;
            end
            default: st_q <= ST_DONE;
          endcase
        end
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  localparam IS_IDLE = 2'd0;
  localparam IS_WAIT = 2'd1;
  localparam IS_OFF  = 2'd2;
  localparam IS_SHIP = 2'd3;
  reg [1:0]  is_q;
  reg [15:0] dly_q;
  reg [31:0] unit_q;
  reg        adp_q;
  wire       tick = (unit_q == UNIT_CYC - 1);
  wire       adp_rise = adp_s & ~adp_q;
  wire [15:0] wdata = {sh_q, lo_q};
  wire wr_ctrl = wr_stb && ptr_q == `SBI_PTR_CTRL;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      is_q <= IS_IDLE; dly_q <= 16'h0000; unit_q <= 32'h0000_0000;
      adp_q <= 1'b0; battery_switch_gate_drive <= 1'b1;
      system_reset_request_bit <= 1'b0;
      battery_disconnect_request_bit <= 1'b0;
      reset_event_flag <= 1'b0; disconnect_event_flag <= 1'b0;
      isolation_delay_q <= `SBI_DELAY_RST;
    end else begin
      adp_q <= adp_s;
      unit_q <= (tick || is_q == IS_IDLE) ? 32'h0000_0000
                                          : unit_q + 32'h0000_0001;
      if (wr_stb && ptr_q == `SBI_PTR_DELAY) isolation_delay_q <= wdata;
      // events set in the clearing read cycle survive
      if (rd_ev_clr) begin
        reset_event_flag <= 1'b0;
        disconnect_event_flag <= 1'b0;
      end
      case (is_q)
        IS_IDLE: begin
          if (wr_ctrl && wdata[`SBI_BIT_RST]) begin
            system_reset_request_bit <= 1'b1;
            is_q <= IS_WAIT; dly_q <= isolation_delay_q;
          end else if (wr_ctrl && wdata[`SBI_BIT_DIS]) begin
            battery_disconnect_request_bit <= 1'b1;
            is_q <= IS_WAIT; dly_q <= isolation_delay_q;
          end
        end
        IS_WAIT: if (tick) begin
          if (dly_q != 16'h0000) dly_q <= dly_q - 16'h0001;
          else if (system_reset_request_bit) begin
            battery_switch_gate_drive <= 1'b0;
            reset_event_flag <= 1'b1;
            dly_q <= isolation_delay_q; is_q <= IS_OFF;
          end else if (!adp_s) begin
            battery_switch_gate_drive <= 1'b0;
            disconnect_event_flag <= 1'b1;
            is_q <= IS_SHIP;
          end
        end
        IS_OFF: if (tick) begin
          if (dly_q != 16'h0000) dly_q <= dly_q - 16'h0001;
          else begin
            battery_switch_gate_drive <= 1'b1;
            system_reset_request_bit <= 1'b0;
            is_q <= IS_IDLE;
          end
        end
        IS_SHIP: if (adp_rise) begin
          battery_switch_gate_drive <= 1'b1;
          battery_disconnect_request_bit <= 1'b0;
          is_q <= IS_IDLE;
        end
        default: is_q <= IS_IDLE;
      endcase
    end
  end
endmodule

// ### verif/sbi_properties.sv
`include "sbi_defs.vh"
module sbi_properties #(
  parameter TIMEOUT_CYC = `SBI_TIMEOUT_CYC
) (
  input logic        mclk,
  input logic        arst_n,
  input logic        scl_i,
  input logic        sda_o,
  input logic        sda_oe,
  input logic        adapter_valid_line,
  input logic        battery_switch_gate_drive,
  input logic        system_reset_request_bit,
  input logic        battery_disconnect_request_bit,
  input logic        reset_event_flag,
  input logic        disconnect_event_flag,
  input logic [15:0] isolation_delay_q
);
  timeunit 1ns;
  timeprecision 1ps;
  int lo_q;
  // margin of 8 covers the pin synchronisers
  always @(posedge mclk or negedge arst_n)
    if (!arst_n)
      lo_q <= 0;
    else
      lo_q <= scl_i ? 0 : lo_q + 1;
  //////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  sequence s_gate_on;
    ##[0:2] battery_switch_gate_drive;
  endsequence
  sequence s_reconnect;
    ##[0:6] battery_switch_gate_drive;
  endsequence
  a_sda_only_low: assert property (sda_oe |-> !sda_o)
    else $error("sda driven high");
  a_sda_stable_high: assert property (scl_i && $past(scl_i)
    |-> $stable(sda_oe)) else $error("sda moved while scl high");
  a_timeout_release: assert property (lo_q > TIMEOUT_CYC + 8
    |-> !sda_oe) else $error("sda held past timeout");
  a_gate_fall_cause: assert property (
    $fell(battery_switch_gate_drive)
    |-> system_reset_request_bit || battery_disconnect_request_bit)
    else $error("gate low without request");
  a_rst_clear_gate: assert property (
    $fell(system_reset_request_bit) |-> s_gate_on)
    else $error("reset bit cleared, gate off");
  a_rst_event_set: assert property ($fell(system_reset_request_bit)
    |-> reset_event_flag) else $error("reset event flag missing");
  a_dis_event_set: assert property (
    $fell(battery_switch_gate_drive) && !system_reset_request_bit
    |-> disconnect_event_flag) else $error("disconnect event flag missing");
  a_dis_clear_gate: assert property (
    $fell(battery_disconnect_request_bit) |-> s_gate_on)
    else $error("disconnect cleared, gate off");
  a_charger_reconnect: assert property (battery_disconnect_request_bit
    && adapter_valid_line && !battery_switch_gate_drive |-> s_reconnect)
    else $error("charger did not reconnect");
  a_delay_reset: assert property ($rose(arst_n)
    |-> isolation_delay_q == `SBI_DELAY_RST) else $error("delay reset");
endmodule
bind sbi_top sbi_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_prop (
  .mclk                           (mclk),
  .arst_n                         (arst_n),
  .scl_i                          (scl_i),
  .sda_o                          (sda_o),
  .sda_oe                         (sda_oe),
  .adapter_valid_line             (adapter_valid_line),
  .battery_switch_gate_drive      (battery_switch_gate_drive),
  .system_reset_request_bit       (system_reset_request_bit),
  .battery_disconnect_request_bit (battery_disconnect_request_bit),
  .reset_event_flag               (reset_event_flag),
  .disconnect_event_flag          (disconnect_event_flag),
  .isolation_delay_q              (isolation_delay_q)
);

// ### verif/sbi_host.sv
module sbi_host (
  input  wire  mclk,
  input  wire  sda,
  output logic scl,
  output logic h_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q;
  logic       k;
  initial begin
    scl = 1'b1;
    h_sda = 1'b1;
  end
  //////////////////////////////
  task w(input int c);
    repeat (c) @(negedge mclk);
  endtask
  // sda moves mid-low so no false start or stop is seen
  task sb(input logic b, output logic r);
    w(4);
    h_sda = b;
    w(4);
    scl = 1'b1;
    w(8);
    r = sda;
    scl = 1'b0;
  endtask
  task st;
    w(4);
    h_sda = 1'b1;
    w(4);
    scl = 1'b1;
    w(8);
    h_sda = 1'b0;
    w(8);
    scl = 1'b0;
  endtask
  task sp;
    w(4);
    h_sda = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    h_sda = 1'b1;
    w(8);
  endtask
  task xb(input [7:0] d, input logic a, output logic [7:0] o,
          output logic ak);
    for (int i = 7; i >= 0; i--)
      sb(d[i], o[i]);
    sb(a, ak);
  endtask
  task wr(input [6:0] ad, input [7:0] p, input [15:0] v,
          output logic [3:0] ak);
    st;
    xb({ad, 1'b0}, 1'b1, q, ak[0]);
    xb(p, 1'b1, q, ak[1]);
    xb(v[7:0], 1'b1, q, ak[2]);
    xb(v[15:8], 1'b1, q, ak[3]);
    sp;
  endtask
  task rd(input [7:0] p, output logic [15:0] v,
          output logic [3:0] ak);
    st;
    xb(8'h12, 1'b1, q, ak[0]);
    xb(p, 1'b1, q, ak[1]);
    st;
    xb(8'h13, 1'b1, q, ak[2]);
    xb(8'hff, 1'b0, v[7:0], ak[3]);
    xb(8'hff, 1'b1, v[15:8], k);
    sp;
  endtask
endmodule

// ### verif/sbi_top_tb_top.sv
module sbi_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        adp = 1'b1;
  wire         scl;
  wire         h_sda;
  wire         sda;
  wire         sda_o;
  wire         sda_oe;
  wire         gate;
  wire         rst_b;
  wire         dis_b;
  wire         rst_ev;
  wire         dis_ev;
  wire  [15:0] dly;
  int          num_errors = 0;
  int          checks = 0;
  int          n;
  logic [15:0] v;
  logic [3:0]  ak;
  logic        k;
  always #5 mclk = ~mclk;
  // pull-up: a released line reads high
  assign sda = (sda_oe ? sda_o : 1'b1) & h_sda;
  sbi_host host (.mclk(mclk), .sda(sda), .scl(scl), .h_sda(h_sda));
  // short counts keep the run brief
  sbi_top #(.TIMEOUT_CYC(200), .UNIT_CYC(10)) DUT (
    .mclk(mclk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .adapter_valid_line(adp),
    .battery_switch_gate_drive(gate), .system_reset_request_bit(rst_b),
    .battery_disconnect_request_bit(dis_b), .reset_event_flag(rst_ev),
    .disconnect_event_flag(dis_ev), .isolation_delay_q(dly));
  //////////////////////////////
  task chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task t_regs;
    chk({gate, rst_b, dis_b, rst_ev, dis_ev, sda_oe}, 16'h0020);
    host.wr(7'h09, 8'h02, 16'h0105, ak);
    chk(ak, 16'h0000);
    chk(dly, 16'h0105);
    host.wr(7'h0a, 8'h02, 16'h0007, ak);
    chk(ak, 16'h000f);
    chk(dly, 16'h0105);
    host.rd(8'h02, v, ak);
    chk(v, 16'h0105);
    chk(ak, 16'h0000);
    host.rd(8'h07, v, ak);
    chk(v, 16'h0000);
    host.wr(7'h09, 8'h02, 16'h0005, ak);
    chk(dly, 16'h0005);
    $display("t_regs done");
  endtask
  task t_tmo;
    // address 0x12: bits 4 and 1 high, then stall in ack
    for (n = 7; n >= 0; n--)
      host.sb(n == 4 || n == 1, k);
    host.w(50);
    chk(sda_oe, 16'h0001);
    host.w(200);
    chk(sda_oe, 16'h0000);
    host.sp;
    $display("t_tmo done");
  endtask
  task t_hard;
    // delay 5 units of 10 cycles, plus one unit for the tick that finds the count at zero
    host.wr(7'h09, 8'h00, 16'h0001, ak);
    chk({ak, rst_b, gate}, 16'h0003);
    for (n = 0; n < 80 && gate; n++)
      host.w(1);
    chk(n >= 24 && n <= 40, 16'h0001);
    for (n = 0; n < 200 && !gate; n++)
      host.w(1);
    chk(n >= 48 && n <= 62, 16'h0001);
    host.w(4);
    chk({rst_b, gate}, 16'h0001);
    host.rd(8'h01, v, ak);
    chk(v, 16'h0001);
    host.rd(8'h01, v, ak);
    chk(v, 16'h0000);
    $display("t_hard done");
  endtask
  task t_disc;
    host.wr(7'h09, 8'h00, 16'h0002, ak);
    // the read outlasts the delay; adapter still present keeps gate on
    host.rd(8'h00, v, ak);
    chk(v, 16'h0002);
    chk({dis_b, gate, dis_ev}, 16'h0006);
    adp = 1'b0;
    // gate only moves on a delay tick, so allow a full unit
    host.w(20);
    chk({dis_b, gate, dis_ev}, 16'h0005);
    adp = 1'b1;
    host.w(10);
    chk({dis_b, gate}, 16'h0001);
    host.rd(8'h01, v, ak);
    chk(v, 16'h0002);
    $display("t_disc done");
  endtask
  initial begin
    host.w(2);
    arst_n = 1'b1;
    host.w(4);
    t_regs;
    host.st;
    t_tmo;
    t_hard;
    t_disc;
    final_report;
  end
  initial begin
    #200_000;
    num_errors++;
    final_report;
  end
endmodule
